// >>> common/rds_pkg.sv
// Shared constants and types for the run permit and dwell sequencer
package rds_pkg;

    // Frequencies count in 0.01 Hz, times in 0.1 s
    localparam int FREQ_W = 16;
    localparam int TIME_W = 16;
    localparam int FUNC_W = 6;

    // Terminal function code that makes a terminal the run permit
    localparam logic [5:0] FUNC_RUN_PERMIT = 6'h0D;

    // Run permit policy
    localparam logic PERMIT_ALWAYS = 1'h0;
    localparam logic PERMIT_TERMINAL = 1'h1;

    // Stop policy when the permit terminal goes off
    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_QUICK = 2'h1;
    localparam logic [1:0] STOP_QUICK_RESUME = 2'h2;

    // Control mode that allows dwell (volts per hertz)
    localparam logic [2:0] CTRL_VF = 3'h0;

    // Values after reset of the dwell settings, and the dwell time ceiling
    localparam logic [15:0] DWELL_FREQ_RST = 16'h01F4;
    localparam logic [15:0] DWELL_TIME_RST = 16'h0000;
    localparam logic [15:0] DWELL_TIME_MAX = 16'h0258;

    // One time tick is a tenth of a second
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Synchroniser depth for pin inputs
    localparam int SYNC_DEPTH = 3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ACC_RAMP = 4'h1,
        ST_ACC_DWELL = 4'h2,
        ST_RUN = 4'h3,
        ST_DEC_RAMP = 4'h4,
        ST_DEC_DWELL = 4'h5,
        ST_DEC_STOP = 4'h6,
        ST_QSTOP = 4'h7
    } rds_state_type;

    typedef struct packed {
        logic permit_from_terminal;
        logic [1:0] stop_mode;
        logic [2:0] ctrl_mode;
        logic [15:0] max_freq;
        logic [15:0] acc_time;
        logic [15:0] dec_time;
        logic [15:0] qstop_time;
    } rds_cfg_type;

    typedef struct packed {
        logic [15:0] acc_freq;
        logic [15:0] acc_time;
        logic [15:0] dec_freq;
        logic [15:0] dec_time;
    } rds_dwell_type;

endpackage : rds_pkg

// >>> hw/rds_ramp.sv
// Linear frequency ramp toward a target at a slope set by a ramp time
`timescale 1ns/1ns
module rds_ramp #(
    parameter int TICK_CYC = rds_pkg::TICK_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic [15:0] target_in,
    input wire logic [15:0] up_time_in,
    input wire logic [15:0] down_time_in,
    input wire logic [15:0] max_freq_in,
    output logic [15:0] freq_out,
    output logic at_target_out
);

    logic [15:0] freq;
    logic [15:0] next_freq;
    logic [47:0] acc;
    logic [47:0] next_acc;
    logic [47:0] lim;
    logic [15:0] tm;
    logic up;

    // Slope is max_freq per ramp time; one 0.01 Hz step per cycle at most, but a zero ramp time or max_freq jumps straight to target
    always_comb begin
        up = target_in > freq;
        tm = up ? up_time_in : down_time_in;
        lim = 48'(tm) * 48'(TICK_CYC);
        next_freq = freq;
        next_acc = acc;
        if (clear_in) begin
            next_freq = 16'h0000;
            next_acc = 48'h0;
        end else if (freq == target_in) begin
            next_acc = 48'h0;
        end else if (tm == 16'h0000 || max_freq_in == 16'h0000) begin
            next_freq = target_in;
            next_acc = 48'h0;
        end else if (acc + 48'(max_freq_in) >= lim) begin
            next_acc = acc + 48'(max_freq_in) - lim;
            next_freq = up ? freq + 16'h0001 : freq - 16'h0001;
        end else begin
            next_acc = acc + 48'(max_freq_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            freq <= 16'h0000;
            acc <= 48'h0;
        end else begin
            freq <= next_freq;
            acc <= next_acc;
        end
    end

    assign freq_out = freq;
    assign at_target_out = freq == target_in;

endmodule : rds_ramp

// >>> hw/rds_sequencer.sv
// Run permit gate with acceleration and deceleration dwell sequencing
`timescale 1ns/1ns
module rds_sequencer #(
    parameter int N_TERM = 8,
    parameter int TICK_CYC = rds_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // Pins
    input wire logic RUN_CMD_IN,
    input wire logic BRAKE_CTRL_IN,
    input wire logic [N_TERM-1:0] TERM_IN,
    // Settings
    input wire logic [N_TERM*6-1:0] TERM_FUNC_IN,
    input wire rds_pkg::rds_cfg_type CFG_IN,
    input wire rds_pkg::rds_dwell_type DWELL_IN,
    input wire logic [15:0] FREQ_TARGET_IN,
    // Outputs
    output logic [15:0] FREQ_REF_OUT,
    output logic OUT_BLOCK_OUT,
    output logic PERMIT_OUT,
    output logic [3:0] STATE_OUT
);

    localparam int NP = N_TERM + 2;

    // Reset release through two flops
    logic [1:0] rst_pipe;
    logic rst_n;

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Pin inputs: a change counts once the second and third flops agree
    logic [NP-1:0] s1, s2, s3, pin;
    logic [NP-1:0] next_pin;

    always_comb begin
        next_pin = pin;
        for (int i = 0; i < NP; i++) begin
            if (s2[i] == s3[i]) begin
                next_pin[i] = s3[i];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin <= '0;
        end else begin
            s1 <= {BRAKE_CTRL_IN, RUN_CMD_IN, TERM_IN};
            s2 <= s1;
            s3 <= s2;
            pin <= next_pin;
        end
    end

    logic run_cmd, brake;
    assign run_cmd = pin[N_TERM];
    assign brake = pin[N_TERM+1];

    // Dwell phase is real only with nonzero time and frequency
    function automatic logic dwell_on(input logic [15:0] f,
                                      input logic [15:0] t,
                                      input logic [2:0] mode);
        dwell_on = mode == rds_pkg::CTRL_VF
                   && f != 16'h0000 && t != 16'h0000;
    endfunction : dwell_on

    // Dwell time is held to its sixty second ceiling
    function automatic logic [15:0] dwell_clamp(input logic [15:0] t);
        dwell_clamp = t > rds_pkg::DWELL_TIME_MAX ?
                      rds_pkg::DWELL_TIME_MAX : t;
    endfunction : dwell_clamp

    // Permit is the OR of every terminal assigned the permit function
    logic term_permit;
    logic permit_ok;

    always_comb begin
        term_permit = 1'h0;
        for (int i = 0; i < N_TERM; i++) begin
            if (TERM_FUNC_IN[i*6 +: 6] == rds_pkg::FUNC_RUN_PERMIT) begin
                term_permit = term_permit | pin[i];
            end
        end
        permit_ok = CFG_IN.permit_from_terminal == rds_pkg::PERMIT_ALWAYS
                    || term_permit;
    end

    // Sequencer state
    rds_pkg::rds_state_type state, next_state;
    logic need_fresh, next_need_fresh;
    logic [15:0] dwell_cnt, next_dwell_cnt;
    logic [31:0] pre, next_pre;
    logic ramp_clear;
    logic [15:0] ramp_tgt, up_time, down_time;
    logic [15:0] freq;
    logic at_tgt;
    logic run_ok, active, stop_dwell;
    logic [15:0] acc_t, dec_t;

    rds_ramp #(
        .TICK_CYC(TICK_CYC)
    ) u_ramp (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .clear_in(ramp_clear),
        .target_in(ramp_tgt),
        .up_time_in(up_time),
        .down_time_in(down_time),
        .max_freq_in(CFG_IN.max_freq),
        .freq_out(freq),
        .at_target_out(at_tgt)
    );

    always_comb begin
        acc_t = dwell_clamp(DWELL_IN.acc_time);
        dec_t = dwell_clamp(DWELL_IN.dec_time);
        run_ok = run_cmd && permit_ok && !need_fresh;
        active = state != rds_pkg::ST_IDLE && state != rds_pkg::ST_QSTOP;
        stop_dwell = dwell_on(DWELL_IN.dec_freq, dec_t, CFG_IN.ctrl_mode)
                     && !brake && freq > DWELL_IN.dec_freq;
        next_state = state;
        next_need_fresh = need_fresh;
        next_dwell_cnt = dwell_cnt;
        next_pre = pre;
        ramp_clear = 1'h0;
        ramp_tgt = FREQ_TARGET_IN;
        up_time = CFG_IN.acc_time;
        down_time = CFG_IN.dec_time;
        if (!run_cmd) begin
            next_need_fresh = 1'h0;
        end
        // Dwell timer counts tenths of a second
        if (next_pre >= 32'(TICK_CYC - 1)) begin
            next_pre = 32'h0;
            if (dwell_cnt != 16'h0000) begin
                next_dwell_cnt = dwell_cnt - 16'h0001;
            end
        end else begin
            next_pre = pre + 32'h1;
        end
        case (state)
            rds_pkg::ST_IDLE: begin
                ramp_tgt = 16'h0000;
                if (run_ok) begin
                    if (dwell_on(DWELL_IN.acc_freq, acc_t,
                                 CFG_IN.ctrl_mode)) begin
                        next_state = rds_pkg::ST_ACC_RAMP;
                    end else begin
                        next_state = rds_pkg::ST_RUN;
                    end
                end
            end
            rds_pkg::ST_ACC_RAMP: begin
                ramp_tgt = DWELL_IN.acc_freq;
                if (at_tgt) begin
                    next_state = rds_pkg::ST_ACC_DWELL;
                    next_dwell_cnt = acc_t;
                    next_pre = 32'h0;
                end
            end
            rds_pkg::ST_ACC_DWELL: begin
                ramp_tgt = DWELL_IN.acc_freq;
                if (dwell_cnt == 16'h0000) begin
                    next_state = rds_pkg::ST_RUN;
                end
            end
            rds_pkg::ST_RUN: begin
                // Reference changes just retarget the ramp, no dwell
                ramp_tgt = FREQ_TARGET_IN;
            end
            rds_pkg::ST_DEC_RAMP: begin
                ramp_tgt = DWELL_IN.dec_freq;
                if (at_tgt) begin
                    next_state = rds_pkg::ST_DEC_DWELL;
                    next_dwell_cnt = dec_t;
                    next_pre = 32'h0;
                end
            end
            rds_pkg::ST_DEC_DWELL: begin
                ramp_tgt = DWELL_IN.dec_freq;
                if (dwell_cnt == 16'h0000) begin
                    next_state = rds_pkg::ST_DEC_STOP;
                end
            end
            rds_pkg::ST_DEC_STOP: begin
                ramp_tgt = 16'h0000;
                if (at_tgt) begin
                    next_state = rds_pkg::ST_IDLE;
                end
            end
            rds_pkg::ST_QSTOP: begin
                ramp_tgt = 16'h0000;
                down_time = CFG_IN.qstop_time;
                // Resume policy leaves need_fresh clear, so IDLE restarts
                if (at_tgt) begin
                    next_state = rds_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rds_pkg::ST_IDLE;
                ramp_clear = 1'h1;
            end
        endcase
        // Stop and re-run decisions shared by all running states
        if (active && state != rds_pkg::ST_IDLE && permit_ok) begin
            if (!run_cmd && (state == rds_pkg::ST_RUN
                             || state == rds_pkg::ST_ACC_RAMP
                             || state == rds_pkg::ST_ACC_DWELL)) begin
                next_state = stop_dwell ? rds_pkg::ST_DEC_RAMP
                                        : rds_pkg::ST_DEC_STOP;
            end else if (run_cmd && (state == rds_pkg::ST_DEC_RAMP
                             || state == rds_pkg::ST_DEC_DWELL
                             || state == rds_pkg::ST_DEC_STOP)) begin
                // Re-acceleration never repeats the start dwell
                next_state = rds_pkg::ST_RUN;
            end
        end
        // Permit loss overrides every running state
        if (active && !permit_ok) begin
            if (CFG_IN.stop_mode == rds_pkg::STOP_COAST) begin
                next_state = rds_pkg::ST_IDLE;
                ramp_clear = 1'h1;
            end else begin
                next_state = rds_pkg::ST_QSTOP;
                if (CFG_IN.stop_mode == rds_pkg::STOP_QUICK) begin
                    next_need_fresh = 1'h1;
                end
            end
        end
    end

    // Output block and registered outputs
    logic next_block;

    always_comb begin
        next_block = (state == rds_pkg::ST_IDLE && freq == 16'h0000)
                     || ramp_clear;
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            state <= rds_pkg::ST_IDLE;
            need_fresh <= 1'h0;
            dwell_cnt <= rds_pkg::DWELL_TIME_RST;
            pre <= 32'h0;
            FREQ_REF_OUT <= 16'h0000;
            OUT_BLOCK_OUT <= 1'h1;
            PERMIT_OUT <= 1'h0;
            STATE_OUT <= 4'h0;
        end else begin
            state <= next_state;
            need_fresh <= next_need_fresh;
            dwell_cnt <= next_dwell_cnt;
            pre <= next_pre;
            FREQ_REF_OUT <= ramp_clear ? 16'h0000 : freq;
            OUT_BLOCK_OUT <= next_block;
            PERMIT_OUT <= permit_ok;
            STATE_OUT <= next_state;
        end
    end

endmodule : rds_sequencer

// >>> verif/rds_term_src.sv
// Model of the terminal block and the run command source
`timescale 1ns/1ns
module rds_term_src #(
    parameter int N_TERM = 8
) (
    // Clock
    input wire logic clk_in,
    // Requests from the bench
    input wire logic run_req_in,
    input wire logic permit_req_in,
    input wire logic [2:0] permit_idx_in,
    // Pins toward the block
    output logic run_out,
    output logic [N_TERM-1:0] term_out
);
    // Contacts move just after the edge, as a switch would
    always_ff @(posedge clk_in) begin
        run_out <= run_req_in;
        // One assignment per edge: only the chosen contact carries the permit
        term_out <= {{(N_TERM-1){1'b0}}, permit_req_in}
                    << permit_idx_in;
    end
endmodule : rds_term_src

// >>> verif/rds_sequencer_sva.sv
// Port checker for the run permit and dwell sequencer
`timescale 1ns/1ns
module rds_sequencer_sva #(
    parameter int N_TERM = 8,
    parameter int TICK_CYC = 10
) (
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    input wire rds_pkg::rds_cfg_type CFG_IN,
    input wire rds_pkg::rds_dwell_type DWELL_IN,
    input wire logic [15:0] FREQ_REF_OUT,
    input wire logic OUT_BLOCK_OUT,
    input wire logic PERMIT_OUT,
    input wire logic [3:0] STATE_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN);
    logic [31:0] dwell_cyc;
    logic [31:0] next_dwell_cyc;
    logic [31:0] dwell_len;
    assign dwell_len = 32'(DWELL_IN.acc_time) * 32'(TICK_CYC);
    always_comb begin
        next_dwell_cyc = (STATE_OUT == 4'h2) ? dwell_cyc + 32'h1 : 32'h0;
    end
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            dwell_cyc <= 32'h0;
        end else begin
            dwell_cyc <= next_dwell_cyc;
        end
    end
    sequence s_acc_hold;
        STATE_OUT == 4'h2 ##1 STATE_OUT == 4'h2;
    endsequence
    sequence s_dec_hold;
        STATE_OUT == 4'h5 ##1 STATE_OUT == 4'h5;
    endsequence
    property p_acc_freq;
        s_acc_hold |-> FREQ_REF_OUT == DWELL_IN.acc_freq;
    endproperty
    property p_dec_freq;
        s_dec_hold |-> FREQ_REF_OUT == DWELL_IN.dec_freq;
    endproperty
    // Tolerance of two cycles covers the cycle the state stays in dwell after the dwell count reaches zero
    property p_acc_len;
        $past(STATE_OUT) == 4'h2 && STATE_OUT == 4'h3
            |-> dwell_cyc + 32'h2 >= dwell_len && dwell_cyc <= dwell_len + 32'h2;
    endproperty
    property p_dwell_mode;
        STATE_OUT == 4'h2 || STATE_OUT == 4'h5
            |-> CFG_IN.ctrl_mode == rds_pkg::CTRL_VF;
    endproperty
    property p_acc_skip;
        STATE_OUT == 4'h2 |-> DWELL_IN.acc_freq != 16'h0000
            && DWELL_IN.acc_time != 16'h0000;
    endproperty
    property p_no_redwell;
        $past(STATE_OUT) >= 4'h4 |-> STATE_OUT != 4'h2;
    endproperty
    property p_qstop_mode;
        STATE_OUT == 4'h7 |-> CFG_IN.stop_mode != rds_pkg::STOP_COAST;
    endproperty
    property p_coast;
        $fell(PERMIT_OUT) && CFG_IN.permit_from_terminal
            && CFG_IN.stop_mode == rds_pkg::STOP_COAST
            |-> ##[0:2] (STATE_OUT == 4'h0 && OUT_BLOCK_OUT
            && FREQ_REF_OUT == 16'h0000);
    endproperty
    property p_always;
        (CFG_IN.permit_from_terminal == rds_pkg::PERMIT_ALWAYS) [*6]
            |-> PERMIT_OUT;
    endproperty
    property p_refuse;
        STATE_OUT == 4'h0 && !PERMIT_OUT && CFG_IN.permit_from_terminal
            |=> STATE_OUT == 4'h0 || PERMIT_OUT;
    endproperty
    a_acc_freq: assert property (p_acc_freq) else $error("acc dwell freq");
    a_dec_freq: assert property (p_dec_freq) else $error("dec dwell freq");
    a_acc_len: assert property (p_acc_len) else $error("acc dwell length");
    a_dwell_mode: assert property (p_dwell_mode) else $error("dwell mode");
    a_acc_skip: assert property (p_acc_skip) else $error("dwell skip");
    a_no_redwell: assert property (p_no_redwell) else $error("redwell");
    a_qstop_mode: assert property (p_qstop_mode) else $error("qstop");
    a_coast: assert property (p_coast) else $error("coast stop");
    a_always: assert property (p_always) else $error("permit");
    a_refuse: assert property (p_refuse) else $error("run refused");
endmodule : rds_sequencer_sva
bind rds_sequencer rds_sequencer_sva #(.N_TERM(N_TERM), .TICK_CYC(TICK_CYC))
    i_rds_sequencer_sva (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN),
    .CFG_IN(CFG_IN), .DWELL_IN(DWELL_IN), .FREQ_REF_OUT(FREQ_REF_OUT),
    .OUT_BLOCK_OUT(OUT_BLOCK_OUT), .PERMIT_OUT(PERMIT_OUT),
    .STATE_OUT(STATE_OUT));

// >>> verif/rds_sequencer_tb_top.sv
// Self-checking bench for the run permit and dwell sequencer
`timescale 1ns/1ns
module rds_sequencer_tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic [15:0] f;
        logic [15:0] t;
        logic acc_dw;
        logic dec_dw;
    } rds_row_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic run_req = 1'b0;
    logic permit_req = 1'b0;
    logic brake = 1'b0;
    logic run;
    logic [7:0] term;
    logic [47:0] func = 48'h0;
    rds_pkg::rds_cfg_type cfg = '{1'b0, 2'h0, 3'h0, 16'h1388, 16'h0000,
        16'h0000, 16'h0000};
    rds_pkg::rds_dwell_type dwell = '{rds_pkg::DWELL_FREQ_RST, 16'h0002,
        rds_pkg::DWELL_FREQ_RST, 16'h0002};
    logic [15:0] freq;
    logic blk;
    logic permit;
    logic [3:0] state;
    logic [7:0] seen = 8'h00;
    int n_fail = 0;
    int n_checks = 0;
    rds_row_type rows [4] = '{'{3'h0, 16'h01F4, 16'h0002, 1'b1, 1'b1},
        '{3'h0, 16'h0000, 16'h0002, 1'b0, 1'b1},
        '{3'h0, 16'h01F4, 16'h0000, 1'b0, 1'b1},
        '{3'h1, 16'h01F4, 16'h0002, 1'b0, 1'b0}};
    always #25 clk = ~clk;
    always @(posedge clk) seen[state[2:0]] <= 1'b1;
    rds_term_src #(.N_TERM(8)) i_rds_term_src (.clk_in(clk),
        .run_req_in(run_req), .permit_req_in(permit_req),
        .permit_idx_in(3'h3), .run_out(run), .term_out(term));
    rds_sequencer #(.N_TERM(8), .TICK_CYC(10)) i_rds_sequencer (
        .CLK_SYS_IN(clk), .NRST_IN(nrst), .RUN_CMD_IN(run),
        .BRAKE_CTRL_IN(brake), .TERM_IN(term), .TERM_FUNC_IN(func),
        .CFG_IN(cfg), .DWELL_IN(dwell), .FREQ_TARGET_IN(16'h03E8),
        .FREQ_REF_OUT(freq), .OUT_BLOCK_OUT(blk), .PERMIT_OUT(permit),
        .STATE_OUT(state));
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Sampled on the falling edge so the state has settled
    task wait_st(input logic [3:0] s);
        for (int i = 0; i < 800 && state !== s; i++) @(negedge clk);
        check(16'(state), 16'(s));
    endtask : wait_st
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #2_000_000;
        n_fail++;
        conclude();
    end
    initial begin
        func[23:18] = rds_pkg::FUNC_RUN_PERMIT;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        check(16'(blk), 16'h0001);
        foreach (rows[i]) begin
            @(posedge clk);
            cfg.ctrl_mode <= rows[i].mode;
            dwell.acc_freq <= rows[i].f;
            dwell.acc_time <= rows[i].t;
            seen = 8'h00;
            run_req <= 1'b1;
            wait_st(4'h3);
            check(16'(seen[2]), 16'(rows[i].acc_dw));
            repeat (5) @(posedge clk);
            check(freq, 16'h03E8);
            check(16'(blk), 16'h0000);
            seen = 8'h00;
            run_req <= 1'b0;
            wait_st(4'h0);
            check(16'(seen[5]), 16'(rows[i].dec_dw));
            check(16'(seen[7]), 16'h0000);
            $display("row %0d done", i);
        end
        @(posedge clk);
        cfg.ctrl_mode <= 3'h0;
        run_req <= 1'b1;
        wait_st(4'h3);
        @(posedge clk);
        brake <= 1'b1;
        repeat (6) @(posedge clk);
        seen = 8'h00;
        run_req <= 1'b0;
        wait_st(4'h0);
        check(16'(seen[5]), 16'h0000);
        $display("brake test done");
        @(posedge clk);
        brake <= 1'b0;
        run_req <= 1'b1;
        wait_st(4'h3);
        @(posedge clk);
        run_req <= 1'b0;
        wait_st(4'h5);
        seen = 8'h00;
        @(posedge clk);
        run_req <= 1'b1;
        wait_st(4'h3);
        check(16'(seen[2]), 16'h0000);
        $display("reacceleration test done");
        @(posedge clk);
        // Permit contact must be closed before the policy needs it
        permit_req <= 1'b1;
        repeat (8) @(posedge clk);
        cfg.permit_from_terminal <= rds_pkg::PERMIT_TERMINAL;
        repeat (4) @(posedge clk);
        check(16'(state), 16'h0003);
        permit_req <= 1'b0;
        wait_st(4'h0);
        repeat (2) @(posedge clk);
        check(16'(blk), 16'h0001);
        repeat (20) @(posedge clk);
        check(16'(state), 16'h0000);
        $display("coast test done");
        cfg.stop_mode <= rds_pkg::STOP_QUICK;
        permit_req <= 1'b1;
        wait_st(4'h3);
        seen = 8'h00;
        @(posedge clk);
        permit_req <= 1'b0;
        wait_st(4'h0);
        check(16'(seen[7]), 16'h0001);
        @(posedge clk);
        permit_req <= 1'b1;
        repeat (30) @(posedge clk);
        check(16'(state), 16'h0000);
        run_req <= 1'b0;
        repeat (10) @(posedge clk);
        run_req <= 1'b1;
        wait_st(4'h3);
        $display("quick stop test done");
        @(posedge clk);
        cfg.stop_mode <= rds_pkg::STOP_QUICK_RESUME;
        permit_req <= 1'b0;
        wait_st(4'h0);
        @(posedge clk);
        permit_req <= 1'b1;
        wait_st(4'h3);
        $display("resume test done");
        @(posedge clk);
        run_req <= 1'b0;
        wait_st(4'h0);
        @(posedge clk);
        func[23:18] <= 6'h0C;
        run_req <= 1'b1;
        repeat (30) @(posedge clk);
        check(16'(state), 16'h0000);
        check(16'(permit), 16'h0000);
        $display("terminal code test done");
        conclude();
    end
endmodule : rds_sequencer_tb_top
